/* File: dec_map.svh */
// Register offsets, field positions, reset values and widths of the
// debug event combiner. Assumes inclusion by bare name, once per unit.
`ifndef DEC_MAP_SVH
`define DEC_MAP_SVH

// ****************************************************************
// Register byte offsets and combiner address field codes
// ****************************************************************
`define DEC_CTRL       8'h00
`define DEC_SW_COUNT   8'h04
`define DEC_PMEM_SIZE  8'h08
`define DEC_PREV_PC    8'h0C
`define DEC_STATUS     8'h10
`define DEC_MASK       8'h14
`define DEC_COMB_BASE  2'h1
`define DEC_COMB_CFG   2'h0
`define DEC_COMB_SELLO 2'h1
`define DEC_COMB_SELHI 2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define DEC_CTRL_RUN    0
`define DEC_CTRL_CLR    1
`define DEC_CTRL_OOB    2
`define DEC_CFG_EN      0
`define DEC_CFG_AND     1
`define DEC_CFG_LAST    2
`define DEC_CFG_ACT     5
`define DEC_ST_OOB      4
`define DEC_ST_WRAP     5

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define DEC_NCOMB       4
`define DEC_NMEM        8
`define DEC_NBP         32
`define DEC_SEL_W       6
`define DEC_PC_W        16
`define DEC_NST         6
`define DEC_PMEM_RST    16'h8000
`endif

/* File: dec_pkg.sv */
// Types shared by the debug event combiner modules.
// Assumes dec_map.svh sits in the include path.
package dec_pkg;
    typedef enum logic [1:0] {
        DEC_BUS_IDLE = 2'b01,
        DEC_BUS_RD   = 2'b10
    } dec_bus_t;

    typedef enum logic [1:0] {
        DEC_ACT_NONE = 2'h0,
        DEC_ACT_HALT = 2'h1,
        DEC_ACT_TRIG = 2'h2,
        DEC_ACT_BOTH = 2'h3
    } dec_act_t;
endpackage

/* File: dec_combiner.sv */
// One event combiner: sequence or latched-AND over up to eight members.
// Assumes member hits are one-cycle pulses on clk.
`timescale 1ns/100ps
`include "dec_map.svh"
module dec_combiner (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Configuration
    input  wire logic       en,
    input  wire logic       and_mode,
    input  wire logic [2:0] last,
    input  wire logic       clear,
    // Events
    input  wire logic [7:0] hit,
    output logic            fire
);
    import dec_pkg::*;

    logic [2:0] step;
    logic [7:0] latched;
    logic [7:0] used;
    logic [7:0] next_latched;
    logic [2:0] want;
    logic       next_fire;

    genvar g;
    generate
        for (g = 0; g < `DEC_NMEM; g++) begin : g_used
            assign used[g] = (3'(g) <= last);
        end
    endgenerate

    // Entry listed last is matched first, entry 0 completes
    assign want = 3'(last - step);
    assign next_latched = latched | (hit & used);

    always_comb begin
        next_fire = 1'b0;
        if (en && !clear) begin
            if (and_mode)
                next_fire = ((next_latched & used) == used);
            else
                next_fire = hit[want] && (step == last);
        end
    end

    // ****************************************************************
    // Progress state
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step    <= 3'h0;
            latched <= 8'h00;
        end else if (clear || !en || next_fire) begin
            step    <= 3'h0;
            latched <= 8'h00;
        end else if (and_mode) begin
            latched <= next_latched;
        end else if (hit[want]) begin
            step <= 3'(step + 3'h1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            fire <= 1'b0;
        else
            fire <= next_fire;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_seq_complete: assert property (
        (en && !clear && !and_mode && step == last && hit[want]) |=> fire)
        else $error("sequence end did not fire");
    a_seq_early: assert property (
        (!and_mode && step != last) |=> !fire)
        else $error("sequence fired before last member");
    a_and_all: assert property (
        (fire && $past(and_mode)) |-> $past(((latched | hit) | ~used) == 8'hFF))
        else $error("latched-and fired with member missing");
    a_fire_clears: assert property (
        fire |-> (step == 3'h0 && latched == 8'h00))
        else $error("combiner state kept after fire");
endmodule

/* File: dec_top.sv */
// Debug event logic: four combiners, stopwatch, out-of-bounds detector.
// Assumes breakpoint hits, cycle strobe and PCs come from logic on clk.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "dec_map.svh"

// How it works
// - Four independent combiners, each reducing up to eight member events to one.
// - A combiner event can request halt, trigger-out, or both.
// - Combiner members come only from breakpoint hits or combiner outputs.
// - In sequence mode earlier members never halt; only the final one fires.
// - Sequence runs bottom-up: highest entry matched first, entry 0 completes.
// - Latched-AND records each member hit, fires once all are recorded.
// - A combiner output can be a member of another combiner.
// - 32-bit stopwatch counts every instruction cycle while running.
// - Count advances per cycle, so multi-cycle instructions add all cycles.
// - Fetched PC at or beyond program memory size raises an event.
// - Out-of-bounds event acts only when enabled, and then halts.
// - PC of last executed instruction is kept readable after that halt.
// - Each action selects halt only, trigger only, or both; here combiner action code 0 selects neither, and out-of-bounds always halts.
module dec_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // Breakpoint comparators and core
    input  wire logic [`DEC_NBP-1:0]    bp_hit,
    input  wire logic                   instr_cycle,
    input  wire logic                   fetch_valid,
    input  wire logic [`DEC_PC_W-1:0]   fetch_pc,
    input  wire logic                   exec_valid,
    input  wire logic [`DEC_PC_W-1:0]   exec_pc,
    // Halt controller, trigger pin, interrupt
    output logic                        halt_req,
    output logic                        trig_out,
    output logic                        irq
);
    import dec_pkg::*;

    // ****************************************************************
    // Register state
    // ****************************************************************
    dec_bus_t                 bus_state;
    logic                     wr_pend;
    logic [7:0]               wr_addr;
    logic [7:0]               rd_addr;
    logic                     sw_run;
    logic                     oob_en;
    logic [31:0]              sw_count;
    logic [`DEC_PC_W-1:0]     pmem_size;
    logic [`DEC_PC_W-1:0]     last_pc;
    logic [`DEC_PC_W-1:0]     prev_pc;
    logic [`DEC_NST-1:0]      status;
    logic [`DEC_NST-1:0]      mask;
    logic [7:0]               cfg    [`DEC_NCOMB];
    logic [47:0]              sel    [`DEC_NCOMB];
    logic [`DEC_NCOMB-1:0]    cfg_wr;
    logic [`DEC_NCOMB-1:0]    comb_fire;
    logic [`DEC_NCOMB-1:0]    act_halt;
    logic [`DEC_NCOMB-1:0]    act_trig;
    logic [63:0]              src;
    logic [`DEC_NST-1:0]      st_set;
    logic                     acc;
    logic                     do_wr;
    logic                     sw_clr_wr;
    logic                     oob_hit;
    logic                     sw_wrap;
    logic                     st_rd;
    logic [31:0]              rd_val;

    assign acc       = hsel && hready && htrans[1];
    assign do_wr     = wr_pend;
    assign sw_clr_wr = do_wr && wr_addr == `DEC_CTRL && hwdata[`DEC_CTRL_CLR];
    assign st_rd     = bus_state == DEC_BUS_RD && rd_addr == `DEC_STATUS;

    // ****************************************************************
    // Bus slave: writes take no wait, reads take one
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_state <= DEC_BUS_IDLE;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            rd_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            hresp   <= 1'b0;
            wr_pend <= acc && hwrite;
            if (acc)
                wr_addr <= haddr[7:0];
            case (bus_state)
                DEC_BUS_IDLE: begin
                    if (acc && !hwrite) begin
                        rd_addr   <= haddr[7:0];
                        hreadyout <= 1'b0;
                        bus_state <= DEC_BUS_RD;
                    end
                end
                DEC_BUS_RD: begin
                    // Wait state lets a write just before land first
                    hrdata    <= rd_val;
                    hreadyout <= 1'b1;
                    bus_state <= DEC_BUS_IDLE;
                end
                default: begin
                    hreadyout <= 1'b1;
                    bus_state <= DEC_BUS_IDLE;
                end
            endcase
        end
    end

    // Unmapped addresses read as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (rd_addr[7:6] == `DEC_COMB_BASE) begin
            case (rd_addr[3:2])
                `DEC_COMB_CFG:   rd_val = {24'h0, cfg[rd_addr[5:4]]};
                `DEC_COMB_SELLO: rd_val = {8'h0, sel[rd_addr[5:4]][23:0]};
                `DEC_COMB_SELHI: rd_val = {8'h0, sel[rd_addr[5:4]][47:24]};
                default:         rd_val = 32'h0000_0000;
            endcase
        end else begin
            case (rd_addr)
                `DEC_CTRL:      rd_val = {29'h0, oob_en, 1'b0, sw_run};
                `DEC_SW_COUNT:  rd_val = sw_count;
                `DEC_PMEM_SIZE: rd_val = {16'h0, pmem_size};
                `DEC_PREV_PC:   rd_val = {16'h0, prev_pc};
                `DEC_STATUS:    rd_val = {26'h0, status};
                `DEC_MASK:      rd_val = {26'h0, mask};
                default:        rd_val = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw_run    <= 1'b0;
            oob_en    <= 1'b0;
            pmem_size <= `DEC_PMEM_RST;
            mask      <= '0;
        end else if (do_wr) begin
            case (wr_addr)
                `DEC_CTRL: begin
                    sw_run <= hwdata[`DEC_CTRL_RUN];
                    oob_en <= hwdata[`DEC_CTRL_OOB];
                end
                `DEC_PMEM_SIZE: pmem_size <= hwdata[`DEC_PC_W-1:0];
                `DEC_MASK:      mask      <= hwdata[`DEC_NST-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Combiner configuration and nesting
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `DEC_NCOMB; i++) begin
                cfg[i] <= 8'h00;
                sel[i] <= 48'h0;
            end
        end else if (do_wr && wr_addr[7:6] == `DEC_COMB_BASE) begin
            case (wr_addr[3:2])
                `DEC_COMB_CFG:   cfg[wr_addr[5:4]] <= hwdata[7:0];
                `DEC_COMB_SELLO: sel[wr_addr[5:4]][23:0] <= hwdata[23:0];
                `DEC_COMB_SELHI: sel[wr_addr[5:4]][47:24] <= hwdata[23:0];
                default: ;
            endcase
        end
    end

    // Source codes 0..31 are breakpoints, 32..35 are combiner outputs;
    // registered outputs keep nested loops free of combinational paths.
    assign src = {28'h0, comb_fire, bp_hit};

    genvar gc, gm;
    generate
        for (gc = 0; gc < `DEC_NCOMB; gc++) begin : g_comb
            logic [7:0] mhit;
            for (gm = 0; gm < `DEC_NMEM; gm++) begin : g_mem
                assign mhit[gm] = src[sel[gc][gm*`DEC_SEL_W +: `DEC_SEL_W]];
            end
            assign cfg_wr[gc] = do_wr && wr_addr[7:6] == `DEC_COMB_BASE
                                && wr_addr[5:4] == 2'(gc);
            assign act_halt[gc] = cfg[gc][`DEC_CFG_ACT];
            assign act_trig[gc] = cfg[gc][`DEC_CFG_ACT+1];
            dec_combiner u_comb (
                .clk      (clk),
                .resetn   (resetn),
                .en       (cfg[gc][`DEC_CFG_EN]),
                .and_mode (cfg[gc][`DEC_CFG_AND]),
                .last     (cfg[gc][`DEC_CFG_LAST +: 3]),
                .clear    (cfg_wr[gc]),
                .hit      (mhit),
                .fire     (comb_fire[gc])
            );
        end
    endgenerate

    // ****************************************************************
    // Stopwatch
    // ****************************************************************
    assign sw_wrap = sw_run && instr_cycle && sw_count == 32'hFFFF_FFFF;

    // Strobe is per instruction cycle, not per retired instruction
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            sw_count <= 32'h0000_0000;
        else if (sw_clr_wr)
            sw_count <= 32'h0000_0000;
        else if (sw_run && instr_cycle)
            sw_count <= sw_count + 32'h0000_0001;
    end

    // ****************************************************************
    // Out-of-bounds detection
    // ****************************************************************
    assign oob_hit = oob_en && fetch_valid && fetch_pc >= pmem_size;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_pc <= '0;
            prev_pc <= '0;
        end else begin
            if (exec_valid)
                last_pc <= exec_pc;
            if (oob_hit)
                prev_pc <= last_pc;
        end
    end

    // ****************************************************************
    // Actions
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            halt_req <= 1'b0;
            trig_out <= 1'b0;
        end else begin
            halt_req <= |(comb_fire & act_halt) || oob_hit;
            trig_out <= |(comb_fire & act_trig);
        end
    end

    // ****************************************************************
    // Interrupt status: read clears, a new event wins
    // ****************************************************************
    assign st_set = {sw_wrap, oob_hit, comb_fire};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= (status & ~{`DEC_NST{st_rd}}) | st_set;
            irq    <= |(status & mask);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_oob_halt: assert property (oob_hit |=> halt_req && status[`DEC_ST_OOB])
        else $error("out-of-bounds fetch did not halt");
    a_oob_gated: assert property (
        (!(oob_en && fetch_valid && fetch_pc >= pmem_size) && !(|(comb_fire & act_halt)))
        |=> !halt_req)
        else $error("halt raised with out-of-bounds disabled or not met");
    a_prev_pc: assert property (oob_hit |=> prev_pc == $past(last_pc))
        else $error("previous PC not kept");
    a_halt_cause: assert property (
        halt_req |-> $past(oob_hit || |(comb_fire & act_halt)))
        else $error("halt without cause");
    a_trig_cause: assert property (
        $past(|(comb_fire & act_trig)) |-> trig_out)
        else $error("trigger action dropped");
    a_sw_count: assert property (
        (sw_run && instr_cycle && !sw_clr_wr) |=> sw_count == $past(sw_count) + 32'h1)
        else $error("stopwatch missed a cycle");
    a_sw_hold: assert property (
        (!instr_cycle && !sw_clr_wr) |=> $stable(sw_count))
        else $error("stopwatch moved without a cycle");
    a_read_wait: assert property ((acc && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
        else $error("read did not take one wait state");
    a_irq_level: assert property (|(status & mask) |=> irq)
        else $error("interrupt not raised");

    c_seq_halt: cover property (comb_fire[0] && !cfg[0][`DEC_CFG_AND] ##1 halt_req);
    c_and_trig: cover property (comb_fire[1] && cfg[1][`DEC_CFG_AND] ##1 trig_out);
    c_nested:   cover property (comb_fire[0] ##[1:20] comb_fire[1]);
    c_oob:      cover property (oob_hit ##1 halt_req);
endmodule

/* File: dec_bp_model.sv */
// Model of the far side: breakpoint comparators and the halt controller.
// Assumes the bench raises hit requests right after a rising clock edge.
`timescale 1ns/100ps
module dec_bp_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Bench requests
    input  wire logic        req_stb,
    input  wire logic [31:0] req_hits,
    // Event block outputs
    input  wire logic        halt_req,
    input  wire logic        trig_out,
    // Comparator pulses and event counts
    output logic      [31:0] bp_hit,
    output int               halt_cnt,
    output int               trig_cnt
);
    // ****************************************************************
    // Comparators
    // ****************************************************************
    // One-cycle pulse per match, idle low between matches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bp_hit <= 32'h0;
        end else begin
            bp_hit <= req_stb ? req_hits : 32'h0;
        end
    end

    // ****************************************************************
    // Halt controller and trigger pin
    // ****************************************************************
    // Counts cycles, so a cause that lingers shows up as extra halts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            halt_cnt <= 0;
            trig_cnt <= 0;
        end else begin
            halt_cnt <= halt_cnt + (halt_req === 1'b1 ? 1 : 0);
            trig_cnt <= trig_cnt + (trig_out === 1'b1 ? 1 : 0);
        end
    end
endmodule

/* File: dec_top_tb.sv */
// Self-checking bench for the debug event block over its register bus.
// Assumes dec_map.svh is in the include path and dec_pkg is compiled.
`timescale 1ns/100ps
`include "dec_map.svh"
module dec_top_tb;
    import dec_pkg::*;
    logic        clk, resetn, hsel, hwrite, hreadyout, hresp, req_stb;
    logic [31:0] haddr, hwdata, hrdata, bp_hit, req_hits;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        instr_cycle, fetch_valid, exec_valid, halt_req, trig_out, irq;
    logic [15:0] fetch_pc, exec_pc;
    int          halt_cnt, trig_cnt, h0, t0, fails, checks;

    dec_top dec_top_inst (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .bp_hit(bp_hit), .instr_cycle(instr_cycle), .fetch_valid(fetch_valid),
        .fetch_pc(fetch_pc), .exec_valid(exec_valid), .exec_pc(exec_pc),
        .halt_req(halt_req), .trig_out(trig_out), .irq(irq));
    dec_bp_model dec_bp_model_inst (.clk(clk), .resetn(resetn), .req_stb(req_stb),
        .req_hits(req_hits), .halt_req(halt_req), .trig_out(trig_out),
        .bp_hit(bp_hit), .halt_cnt(halt_cnt), .trig_cnt(trig_cnt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************************************
    // Reporting
    // ****************************************************************
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ****************************************************************
    // Bus and event drivers
    // ****************************************************************
    // Bounded wait for hready at a rising edge
    task automatic wait_ready();
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) return;
        end
        fails++;
        complete_run();
    endtask
    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] v);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= v;
        wait_ready();
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        wait_ready();
        htrans <= 2'b00;
        wait_ready();
        check(name, hrdata, exp);
    endtask
    task automatic comb_cfg(input int i, input logic [31:0] sel, input logic [31:0] cfg);
        ahb_wr(8'h44 + 8'(16 * i), sel);
        ahb_wr(8'h40 + 8'(16 * i), cfg);
    endtask
    // Long enough for a nested combiner to reach the halt controller
    task automatic hit(input logic [31:0] m);
        req_hits <= m;
        req_stb  <= 1'b1;
        @(posedge clk);
        req_stb  <= 1'b0;
        repeat (7) @(posedge clk);
    endtask
    task automatic ev_chk(input int dh, input int dt);
        check("halts", 32'(halt_cnt - h0), 32'(dh));
        check("trigs", 32'(trig_cnt - t0), 32'(dt));
    endtask
    task automatic run_pc(input logic [15:0] ex, input logic [15:0] fe);
        exec_pc    <= ex;
        exec_valid <= 1'b1;
        @(posedge clk);
        exec_valid  <= 1'b0;
        fetch_pc    <= fe;
        fetch_valid <= 1'b1;
        @(posedge clk);
        fetch_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        {resetn, hwrite, hwdata, htrans, haddr, req_stb, req_hits} = '0;
        {instr_cycle, fetch_valid, fetch_pc, exec_valid, exec_pc} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check("ready rst", hreadyout, 1'b1);
        check("irq rst", irq, 1'b0);
        rd_chk("pmem", `DEC_PMEM_SIZE, 32'h00008000);
        ahb_wr(8'h30, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h30, 32'h0);
        // Every action code on a single-member combiner
        for (int a = 0; a < 4; a++) begin
            h0 = halt_cnt;
            t0 = trig_cnt;
            comb_cfg(3, 32'd20, 32'h1 | 32'(a << 5));
            hit(32'h1 << 20);
            ev_chk(a % 2, a / 2);
        end
        rd_chk("status", `DEC_STATUS, 32'h08);
        rd_chk("status", `DEC_STATUS, 32'h00);
        // Sequence m2 bp7, m1 bp5, m0 bp3; early and foreign hits ignored
        h0 = halt_cnt;
        t0 = trig_cnt;
        comb_cfg(0, 32'h7143, 32'h29);
        hit(32'h1 << 3);
        hit(32'h1 << 7);
        hit(32'h1 << 12);
        hit(32'h1 << 5);
        ev_chk(0, 0);
        hit(32'h1 << 3);
        ev_chk(1, 0);
        check("irq masked", irq, 1'b0);
        ahb_wr(`DEC_MASK, 32'h01);
        repeat (2) @(posedge clk);
        check("irq", irq, 1'b1);
        rd_chk("status", `DEC_STATUS, 32'h01);
        repeat (2) @(posedge clk);
        check("irq clear", irq, 1'b0);
        // Latched AND of bp1 and bp2, trigger only
        h0 = halt_cnt;
        t0 = trig_cnt;
        comb_cfg(1, 32'h81, 32'h47);
        hit(32'h1 << 1);
        ev_chk(0, 0);
        hit(32'h1 << 2);
        ev_chk(0, 1);
        hit(32'h1 << 1);
        ev_chk(0, 1);
        ahb_wr(8'h50, 32'h47);
        hit(32'h1 << 2);
        ev_chk(0, 1);
        // Sequence whose final member is the AND combiner
        comb_cfg(2, 32'h261, 32'h65);
        hit(32'h1 << 9);
        hit(32'h6);
        ev_chk(1, 3);
        // Stopwatch: run and clear set in one write, multi-cycle run counts each cycle
        ahb_wr(`DEC_CTRL, 32'h3);
        instr_cycle <= 1'b1;
        repeat (5) @(posedge clk);
        instr_cycle <= 1'b0;
        @(posedge clk);
        instr_cycle <= 1'b1;
        @(posedge clk);
        instr_cycle <= 1'b0;
        rd_chk("count", `DEC_SW_COUNT, 32'd6);
        ahb_wr(`DEC_CTRL, 32'h0);
        instr_cycle <= 1'b1;
        repeat (3) @(posedge clk);
        instr_cycle <= 1'b0;
        rd_chk("count held", `DEC_SW_COUNT, 32'd6);
        ahb_wr(`DEC_CTRL, 32'h2);
        rd_chk("count clr", `DEC_SW_COUNT, 32'd0);
        rd_chk("ctrl", `DEC_CTRL, 32'h0);
        // Out-of-bounds fetch against a 256-word program memory
        ahb_wr(`DEC_PMEM_SIZE, 32'h100);
        h0 = halt_cnt;
        t0 = trig_cnt;
        run_pc(16'h0010, 16'h0100);
        ev_chk(0, 0);
        ahb_wr(`DEC_CTRL, 32'h4);
        run_pc(16'h0050, 16'h00FF);
        ev_chk(0, 0);
        run_pc(16'h0042, 16'h0100);
        ev_chk(1, 0);
        rd_chk("prev pc", `DEC_PREV_PC, 32'h42);
        // Combiner 1 and 2 fires since the last status read are still pending
        rd_chk("status", `DEC_STATUS, 32'h16);
        check("hresp", hresp, 1'b0);
        complete_run();
    end
endmodule
